// file: rtl/sar_adc_pkg.sv
// Shared constants and types for the successive-approximation converter
// control block.
// Assumes a 32-bit AXI4-Lite register bus, one word per register.
package sar_adc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_MISC = 8'h0C;
    localparam logic [7:0] IDX_PORT = 8'h0D;
    localparam logic [7:0] IDX_CHAN = 8'h16;
    localparam logic [7:0] IDX_RES_LO = 8'h17;
    localparam logic [7:0] IDX_RES_HI = 8'h18;
    localparam logic [7:0] IDX_PIN_SEL = 8'h19;
    localparam logic [7:0] IDX_SPEED = 8'h1A;
    localparam logic [7:0] IDX_START = 8'h20;
    localparam logic [7:0] IDX_LADDER = 8'h21;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h30;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h31;
    localparam logic [7:0] IDX_POWER = 8'h32;

    // Field positions
    localparam int START_BIT = 2;
    localparam int LADDER_OFF_BIT = 2;
    localparam int PULLUP_BIT = 3;
    localparam int STOP_BIT = 0;
    localparam int IRQ_DONE_BIT = 0;
    localparam int SPEED_FAST_BIT = 0;

    // Values after reset, and the first trial code
    localparam logic [3:0] NIB_RST = 4'h0;
    localparam logic [3:0] PORT_LATCH_RST = 4'hF;
    localparam logic [7:0] RESULT_POWERUP = 8'h80;
    localparam logic [7:0] FIRST_TRIAL = 8'h80;

    // Cycles per approximation step, slow and fast speed settings
    localparam int STEP_CYC_SLOW = 16;
    localparam int STEP_CYC_FAST = 4;
    localparam int RES_BITS = 8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [3:0] pin_analog;
        logic [3:0] port_latch;
        logic pullup_en;
        logic ladder_en;
        logic [1:0] chan;
    } analog_ctl_t;

endpackage : sar_adc_pkg

// file: rtl/sar_step_div.sv
// Step-rate divider: one-cycle enable pulse every N clock cycles.
// Assumes i_clear restarts the count so the first step has full length.
`timescale 1ns/1ns
module sar_step_div #(
    parameter int SLOW = sar_adc_pkg::STEP_CYC_SLOW,
    parameter int FAST = sar_adc_pkg::STEP_CYC_FAST
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_arst_n,
    // Control
    input wire logic i_run,
    input wire logic i_clear,
    input wire logic i_fast,
    // Step pulse
    output logic o_step
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    wire logic [7:0] limit = i_fast ? 8'(FAST - 1) : 8'(SLOW - 1);
    wire logic at_end = (cnt_r >= limit);

    assign o_step = i_run && at_end;
    assign cnt_nxt = (i_clear || o_step) ? 8'h00 :
                     (i_run ? cnt_r + 8'h01 : cnt_r);

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule : sar_step_div

// file: rtl/sar_engine.sv
// Successive-approximation sequencer: one sample step, then one trial
// per result bit, MSB first.
// Assumes i_cmp is high when the analog input is at or above the ladder tap.
`timescale 1ns/1ns
module sar_engine #(
    parameter int BITS = sar_adc_pkg::RES_BITS
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_arst_n,
    // Control
    input wire logic i_start,
    input wire logic i_step,
    input wire logic i_cmp,
    // Status and ladder
    output logic o_busy,
    output logic o_sample,
    output logic o_done,
    output logic [BITS-1:0] o_code,
    output logic [BITS-1:0] o_result
);
    typedef enum logic [1:0] {S_IDLE, S_SAMPLE, S_TRIAL} sar_state_t;
    sar_state_t state_r;
    sar_state_t state_nxt;
    logic [BITS-1:0] code_r;
    logic [BITS-1:0] code_nxt;
    logic [BITS-1:0] mask_r;
    logic [BITS-1:0] mask_nxt;
    logic done_nxt;
    wire logic [BITS-1:0] kept = i_cmp ? code_r : (code_r & ~mask_r);

    always_comb begin
        state_nxt = state_r;
        code_nxt = code_r;
        mask_nxt = mask_r;
        done_nxt = 1'b0;
        case (state_r)
            S_IDLE: begin
                if (i_start) begin
                    state_nxt = S_SAMPLE;
                    mask_nxt = BITS'(1) << (BITS - 1);
                    code_nxt = mask_nxt;
                end
            end
            S_SAMPLE: begin
                if (i_step) begin
                    state_nxt = S_TRIAL;
                end
            end
            S_TRIAL: begin
                if (i_step) begin
                    code_nxt = kept | (mask_r >> 1);
                    mask_nxt = mask_r >> 1;
                    if (mask_r[0]) begin
                        code_nxt = kept;
                        state_nxt = S_IDLE;
                        done_nxt = 1'b1;
                    end
                end
            end
            default: state_nxt = S_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_r <= S_IDLE;
            code_r <= '0;
            mask_r <= '0;
            o_done <= 1'b0;
        end else begin
            state_r <= state_nxt;
            code_r <= code_nxt;
            mask_r <= mask_nxt;
            o_done <= done_nxt;
        end
    end

    // Result survives reset; it loads with the done pulse, the same edge
    // at which the start flag drops
    always_ff @(posedge i_mclk) begin
        if (o_done) begin
            o_result <= code_r;
        end
    end

    assign o_busy = (state_r != S_IDLE);
    assign o_sample = (state_r == S_SAMPLE);
    assign o_code = code_r;
endmodule : sar_engine

// file: rtl/sar_adc_control.sv
// Converter control block: AXI4-Lite register file, start/done handshake,
// ladder power, pin mode and interrupt.
// Assumes one clock domain, AXI master obeying single-outstanding rules.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ns

// How it works
// - An 8-bit code is found bit by bit against the ladder for one channel.
// - The pin select register marks each shared pin analog or digital.
// - The speed register sets how fast the conversion steps.
// - The channel register picks which analog input feeds the converter.
// - Writing 1 to bit 2 of the start register begins a conversion.
// - On completion the result is stored and the start flag drops together.
// - The ladder-off flag cuts ladder current in active and standby modes.
// - The result reads as a low nibble and a high nibble, both read-only.
// - Reset leaves the result registers as they were.
// - The result holds until the next conversion completes.
// - Stop mode halts the converter and cuts all ladder current.
// - Reset sets every port latch to 1, so pull-up acts if enabled.
module sar_adc_control #(
    parameter int STEP_SLOW = sar_adc_pkg::STEP_CYC_SLOW,
    parameter int STEP_FAST = sar_adc_pkg::STEP_CYC_FAST
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_arst_n,
    // AXI4-Lite write address and data
    input wire logic [9:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    // AXI4-Lite write response
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // AXI4-Lite read
    input wire logic [9:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // Analog front end
    input wire logic i_cmp,
    output logic [7:0] o_dac_code,
    output logic o_sample,
    output logic [1:0] o_chan_sel,
    output logic o_ladder_en,
    // Pins
    output logic [3:0] o_pin_analog,
    output logic [3:0] o_port_latch,
    output logic o_pullup_en,
    // Interrupt
    output logic o_irq
);
    logic [3:0] chan_r;
    logic [3:0] pin_sel_r;
    logic [3:0] speed_r;
    logic [3:0] port_r;
    logic [3:0] misc_r;
    logic start_flag_r;
    logic ladder_off_r;
    logic stop_r;
    logic irq_stat_r;
    logic irq_mask_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic busy;
    logic done;
    logic step;
    logic sample;
    logic [7:0] code;
    logic [7:0] result;
    sar_adc_pkg::analog_ctl_t ctl;

    // Mapped indices; anything else answers with an error response
    function automatic logic known_idx(input logic [7:0] idx);
        known_idx = (idx == sar_adc_pkg::IDX_MISC) ||
                    (idx == sar_adc_pkg::IDX_PORT) ||
                    (idx == sar_adc_pkg::IDX_CHAN) ||
                    (idx == sar_adc_pkg::IDX_RES_LO) ||
                    (idx == sar_adc_pkg::IDX_RES_HI) ||
                    (idx == sar_adc_pkg::IDX_PIN_SEL) ||
                    (idx == sar_adc_pkg::IDX_SPEED) ||
                    (idx == sar_adc_pkg::IDX_START) ||
                    (idx == sar_adc_pkg::IDX_LADDER) ||
                    (idx == sar_adc_pkg::IDX_IRQ_STAT) ||
                    (idx == sar_adc_pkg::IDX_IRQ_MASK) ||
                    (idx == sar_adc_pkg::IDX_POWER);
    endfunction : known_idx

    // Write side: both channels taken together, one response outstanding
    wire logic wr_go = i_awvalid && i_wvalid && !bvalid_r;
    wire logic [7:0] wr_idx = i_awaddr[9:2];
    wire logic wr_ok = known_idx(wr_idx) && (i_awaddr[1:0] == 2'h0);
    wire logic wr_en = wr_go && wr_ok && i_wstrb[0];
    wire logic [3:0] wnib = i_wdata[3:0];

    // Strobe of one register: an enabled, accepted write to its index
    function automatic logic wr_hit(input logic en, input logic [7:0] at,
            input logic [7:0] idx);
        wr_hit = en && (at == idx);
    endfunction : wr_hit

    wire logic wr_chan = wr_hit(wr_en, wr_idx, sar_adc_pkg::IDX_CHAN);
    wire logic wr_pin = wr_hit(wr_en, wr_idx, sar_adc_pkg::IDX_PIN_SEL);
    wire logic wr_speed = wr_hit(wr_en, wr_idx, sar_adc_pkg::IDX_SPEED);
    wire logic wr_port = wr_hit(wr_en, wr_idx, sar_adc_pkg::IDX_PORT);
    wire logic wr_misc = wr_hit(wr_en, wr_idx, sar_adc_pkg::IDX_MISC);
    wire logic wr_start = wr_hit(wr_en, wr_idx, sar_adc_pkg::IDX_START);
    wire logic wr_ladder = wr_hit(wr_en, wr_idx, sar_adc_pkg::IDX_LADDER);
    wire logic wr_stat = wr_hit(wr_en, wr_idx, sar_adc_pkg::IDX_IRQ_STAT);
    wire logic wr_mask = wr_hit(wr_en, wr_idx, sar_adc_pkg::IDX_IRQ_MASK);
    wire logic wr_power = wr_hit(wr_en, wr_idx, sar_adc_pkg::IDX_POWER);

    // Start only from idle; a set during a conversion is dropped
    wire logic start_req = wr_start &&
                           wnib[sar_adc_pkg::START_BIT] && !busy;

    // Address and data are only taken together, at one edge
    assign o_awready = wr_go;
    assign o_wready = wr_go;
    assign o_bvalid = bvalid_r;
    assign o_bresp = bresp_r;

    // Read side: one cycle from address to data
    wire logic rd_go = i_arvalid && !rvalid_r;
    wire logic [7:0] rd_idx = i_araddr[9:2];
    wire logic rd_ok = known_idx(rd_idx) && (i_araddr[1:0] == 2'h0);
    logic [3:0] rd_nib;

    // Write-only registers read back as zero
    always_comb begin
        rd_nib = 4'h0;
        case (rd_idx)
            sar_adc_pkg::IDX_RES_LO: rd_nib = result[3:0];
            sar_adc_pkg::IDX_RES_HI: rd_nib = result[7:4];
            sar_adc_pkg::IDX_PORT: rd_nib = port_r;
            sar_adc_pkg::IDX_MISC: rd_nib = misc_r;
            sar_adc_pkg::IDX_START:
                rd_nib = {1'b0, start_flag_r, 2'h0};
            sar_adc_pkg::IDX_LADDER:
                rd_nib = {1'b0, ladder_off_r, 2'h0};
            sar_adc_pkg::IDX_IRQ_STAT: rd_nib = {3'h0, irq_stat_r};
            sar_adc_pkg::IDX_IRQ_MASK: rd_nib = {3'h0, irq_mask_r};
            sar_adc_pkg::IDX_POWER: rd_nib = {3'h0, stop_r};
            default: rd_nib = 4'h0;
        endcase
    end

    assign o_arready = rd_go;
    assign o_rvalid = rvalid_r;
    assign o_rdata = rdata_r;
    assign o_rresp = rresp_r;

    // Write response stands until the master takes it
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            bvalid_r <= 1'b0;
            bresp_r <= sar_adc_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_ok ? sar_adc_pkg::RESP_OKAY
                             : sar_adc_pkg::RESP_SLVERR;
        end else if (i_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Read data is frozen at the address edge, so it stands until taken
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= sar_adc_pkg::RESP_OKAY;
        end else if (rd_go) begin
            rvalid_r <= 1'b1;
            rdata_r <= {28'h0000000, rd_nib};
            rresp_r <= rd_ok ? sar_adc_pkg::RESP_OKAY
                             : sar_adc_pkg::RESP_SLVERR;
        end else if (i_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Control registers
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            chan_r <= sar_adc_pkg::NIB_RST;
            pin_sel_r <= sar_adc_pkg::NIB_RST;
            speed_r <= sar_adc_pkg::NIB_RST;
        end else begin
            if (wr_chan) chan_r <= wnib;
            if (wr_pin) pin_sel_r <= wnib;
            if (wr_speed) speed_r <= wnib;
        end
    end

    // Port latch leaves reset high, so an enabled pull-up acts at once
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            misc_r <= sar_adc_pkg::NIB_RST;
            port_r <= sar_adc_pkg::PORT_LATCH_RST;
        end else begin
            if (wr_misc) misc_r <= wnib;
            if (wr_port) port_r <= wnib;
        end
    end

    // Power and interrupt mask controls
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ladder_off_r <= 1'b0;
            stop_r <= 1'b0;
            irq_mask_r <= 1'b0;
        end else begin
            if (wr_ladder) ladder_off_r <= wnib[sar_adc_pkg::LADDER_OFF_BIT];
            if (wr_power) stop_r <= wnib[sar_adc_pkg::STOP_BIT];
            if (wr_mask) irq_mask_r <= wnib[sar_adc_pkg::IRQ_DONE_BIT];
        end
    end

    // Start flag and done status; in both, a set wins over a clear in the same cycle
    wire logic clr_done = wr_stat && wnib[sar_adc_pkg::IRQ_DONE_BIT];

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            start_flag_r <= 1'b0;
        end else if (start_req) begin
            start_flag_r <= 1'b1;
        end else if (done) begin
            start_flag_r <= 1'b0;
        end
    end

    // A done event in the same cycle as a software clear keeps the bit set
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_stat_r <= 1'b0;
        end else if (done) begin
            irq_stat_r <= 1'b1;
        end else if (clr_done) begin
            irq_stat_r <= 1'b0;
        end
    end

    // Level interrupt: high while the done status is set and unmasked
    assign o_irq = irq_stat_r && irq_mask_r;

    // Stop mode freezes the step timer, so the converter does not advance
    sar_step_div #(
        .SLOW(STEP_SLOW),
        .FAST(STEP_FAST)
    ) u_div (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_run(busy && !stop_r),
        .i_clear(start_req),
        .i_fast(speed_r[sar_adc_pkg::SPEED_FAST_BIT]),
        .o_step(step)
    );

    // Result register changes only on completion and holds until then
    sar_engine #(
        .BITS(sar_adc_pkg::RES_BITS)
    ) u_sar (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_start(start_req),
        .i_step(step),
        .i_cmp(i_cmp),
        .o_busy(busy),
        .o_sample(sample),
        .o_done(done),
        .o_code(code),
        .o_result(result)
    );

    // Stop mode cuts the ladder whatever the off flag holds
    assign ctl.pin_analog = pin_sel_r;
    assign ctl.port_latch = port_r;
    assign ctl.pullup_en = misc_r[sar_adc_pkg::PULLUP_BIT];
    assign ctl.ladder_en = !ladder_off_r && !stop_r;
    assign ctl.chan = chan_r[1:0];

    assign o_pin_analog = ctl.pin_analog;
    assign o_port_latch = ctl.port_latch;
    assign o_pullup_en = ctl.pullup_en;
    assign o_ladder_en = ctl.ladder_en;
    assign o_chan_sel = ctl.chan;
    assign o_dac_code = code;
    assign o_sample = sample;
endmodule : sar_adc_control

// file: bench/sar_adc_control_checker.sv
// Checker for the converter control block ports.
// Assumes it is bound to sar_adc_control and sees only its ports.
`timescale 1ns/1ns
module sar_adc_control_checker (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_arst_n,
    // Register bus
    input wire logic [9:0] i_awaddr,
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic [1:0] o_bresp,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic [9:0] i_araddr,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0] o_rresp,
    input wire logic o_rvalid,
    input wire logic i_rready,
    // Front end, pins, interrupt
    input wire logic i_cmp,
    input wire logic [7:0] o_dac_code,
    input wire logic o_sample,
    input wire logic [1:0] o_chan_sel,
    input wire logic o_ladder_en,
    input wire logic [3:0] o_pin_analog,
    input wire logic [3:0] o_port_latch,
    input wire logic o_pullup_en,
    input wire logic o_irq
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_arst_n);
    sequence wr_take;
        i_awvalid && i_wvalid && !o_bvalid;
    endsequence
    // A write that really lands on one register
    sequence wr_to(logic [7:0] idx);
        wr_take ##0 i_wstrb[0] && i_awaddr == {idx, 2'b00};
    endsequence
    a_write_answer: assert property (wr_take |=> o_bvalid)
        else $error("write not answered");
    a_resp_hold: assert property (o_bvalid && !i_bready
        |=> o_bvalid && $stable(o_bresp)) else $error("bresp dropped");
    a_resp_drop: assert property (o_bvalid && i_bready
        |=> !o_bvalid) else $error("bvalid stuck");
    a_no_accept: assert property (o_bvalid
        |-> !o_awready && !o_wready) else $error("write taken early");
    a_read_answer: assert property (i_arvalid && !o_rvalid
        |=> o_rvalid) else $error("read not answered");
    a_read_hold: assert property (o_rvalid && !i_rready
        |=> o_rvalid && $stable(o_rdata)) else $error("rdata moved");
    a_rdata_narrow: assert property (o_rvalid
        |-> o_rdata[31:4] == 28'h0) else $error("rdata wide");
    a_ladder_cut: assert property (wr_to(sar_adc_pkg::IDX_LADDER)
        ##0 i_wdata[2] |=> !o_ladder_en) else $error("ladder on");
    a_chan_follow: assert property (wr_to(sar_adc_pkg::IDX_CHAN)
        |=> o_chan_sel == $past(i_wdata[1:0])) else $error("chan");
    a_pin_follow: assert property (wr_to(sar_adc_pkg::IDX_PIN_SEL)
        |=> o_pin_analog == $past(i_wdata[3:0])) else $error("pins");
    a_first_trial: assert property ($rose(o_sample)
        |-> o_dac_code == sar_adc_pkg::FIRST_TRIAL) else $error("trial");
    a_sample_len: assert property ($rose(o_sample)
        |=> o_sample [*3]) else $error("sample step short");
endmodule : sar_adc_control_checker

bind sar_adc_control sar_adc_control_checker u_chk (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_awaddr(i_awaddr),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
    .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
    .i_rready(i_rready), .i_cmp(i_cmp), .o_dac_code(o_dac_code),
    .o_sample(o_sample), .o_chan_sel(o_chan_sel),
    .o_ladder_en(o_ladder_en), .o_pin_analog(o_pin_analog),
    .o_port_latch(o_port_latch), .o_pullup_en(o_pullup_en),
    .o_irq(o_irq)
);

// file: bench/sar_adc_control_bench.sv
// Self-checking bench for the converter control block.
// Assumes the bound checker; plays bus master and comparator itself.
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
fail_count++; $display("[FAIL] %0t mismatch", $time); end end
`define WAIT_FOR(c) n = 0; do begin @(posedge i_mclk); n++; \
end while (!(c) && n < 400); if (n >= 400) fail_count++;
module sar_adc_control_bench;
    localparam int NS = 8;
    localparam int NF = 4;
    logic i_mclk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_awvalid = 1'b0;
    logic i_wvalid = 1'b0;
    logic i_bready = 1'b0;
    logic i_arvalid = 1'b0;
    logic i_rready = 1'b0;
    logic i_cmp = 1'b0;
    logic [9:0] i_awaddr = 10'h0;
    logic [9:0] i_araddr = 10'h0;
    logic [31:0] i_wdata = 32'h0;
    logic [3:0] i_wstrb = 4'hF;
    logic [7:0] ana = 8'h0;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_sample;
    logic o_ladder_en, o_pullup_en, o_irq;
    logic [1:0] o_bresp, o_rresp, o_chan_sel;
    logic [31:0] o_rdata;
    logic [7:0] o_dac_code;
    logic [3:0] o_pin_analog, o_port_latch, pins;
    logic [33:0] exp_q[$];
    int fail_count = 0;
    int total_checks = 0;
    int seed = 32'h4801;
    int cyc = 0;
    int take, t0, n, nstep;
    sar_adc_control #(.STEP_SLOW(NS), .STEP_FAST(NF)) u_dut (
        .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_awaddr(i_awaddr),
        .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
        .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
        .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
        .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
        .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
        .i_rready(i_rready), .i_cmp(i_cmp), .o_dac_code(o_dac_code),
        .o_sample(o_sample), .o_chan_sel(o_chan_sel),
        .o_ladder_en(o_ladder_en), .o_pin_analog(o_pin_analog),
        .o_port_latch(o_port_latch), .o_pullup_en(o_pullup_en),
        .o_irq(o_irq)
    );
    always #50 i_mclk = ~i_mclk;
    always @(posedge i_mclk) cyc <= cyc + 1;
    // Ideal comparator: the search then lands exactly on ana
    always @(posedge i_mclk) i_cmp <= (o_dac_code <= ana);
    always @(posedge i_mclk) begin
        if (o_bvalid === 1'b1 && i_bready === 1'b1) begin
            `CHK({o_bresp, 32'h0}, exp_q.pop_front())
        end
        if (o_rvalid === 1'b1 && i_rready === 1'b1) begin
            `CHK({o_rresp, o_rdata}, exp_q.pop_front())
        end
    end
    // Response ready comes a random cycle late to exercise the hold
    task automatic wr(input logic [7:0] idx, input logic [3:0] d,
            input logic [1:0] rsp = sar_adc_pkg::RESP_OKAY);
        exp_q.push_back({rsp, 32'h0});
        i_awaddr <= {idx, 2'b00};
        i_wdata <= {28'h0, d};
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        `WAIT_FOR(o_awready === 1'b1)
        take = cyc;
        i_awvalid <= 1'b0;
        i_wvalid <= 1'b0;
        repeat ($random(seed) & 1) @(posedge i_mclk);
        i_bready <= 1'b1;
        `WAIT_FOR(o_bvalid === 1'b1)
        i_bready <= 1'b0;
        @(posedge i_mclk);
    endtask : wr
    task automatic rd(input logic [7:0] idx, input logic [3:0] d,
            input logic [1:0] rsp = sar_adc_pkg::RESP_OKAY);
        exp_q.push_back({rsp, 28'h0, d});
        i_araddr <= {idx, 2'b00};
        i_arvalid <= 1'b1;
        `WAIT_FOR(o_arready === 1'b1)
        i_arvalid <= 1'b0;
        repeat ($random(seed) & 1) @(posedge i_mclk);
        i_rready <= 1'b1;
        `WAIT_FOR(o_rvalid === 1'b1)
        i_rready <= 1'b0;
        @(posedge i_mclk);
    endtask : rd
    task automatic give_verdict();
        $display("checks %0d fails %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #(100 * 5000);
        fail_count++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge i_mclk);
        `CHK(o_port_latch, sar_adc_pkg::PORT_LATCH_RST)
        `CHK(o_ladder_en, 1'b1)
        i_arst_n <= 1'b1;
        @(posedge i_mclk);
        rd(sar_adc_pkg::IDX_START, 4'h0);
        rd(sar_adc_pkg::IDX_PORT, 4'hF);
        for (int i = 0; i < 4; i++) begin
            pins = 4'($random(seed));
            wr(sar_adc_pkg::IDX_CHAN, 4'(i));
            `CHK(o_chan_sel, 2'(i))
            wr(sar_adc_pkg::IDX_PIN_SEL, pins);
            `CHK(o_pin_analog, pins)
        end
        rd(sar_adc_pkg::IDX_CHAN, 4'h0);
        wr(sar_adc_pkg::IDX_MISC, 4'h8);
        `CHK(o_pullup_en, 1'b1)
        wr(sar_adc_pkg::IDX_PORT, 4'h0);
        `CHK(o_port_latch, 4'h0)
        wr(8'h3F, 4'h5, sar_adc_pkg::RESP_SLVERR);
        rd(8'h3F, 4'h0, sar_adc_pkg::RESP_SLVERR);
        wr(sar_adc_pkg::IDX_LADDER, 4'h4);
        `CHK(o_ladder_en, 1'b0)
        wr(sar_adc_pkg::IDX_LADDER, 4'h0);
        wr(sar_adc_pkg::IDX_POWER, 4'h1);
        `CHK(o_ladder_en, 1'b0)
        wr(sar_adc_pkg::IDX_POWER, 4'h0);
        `CHK(o_ladder_en, 1'b1)
        wr(sar_adc_pkg::IDX_IRQ_MASK, 4'h1);
        for (int s = 0; s < 2; s++) begin
            nstep = s ? NF : NS;
            wr(sar_adc_pkg::IDX_SPEED, 4'(s));
            ana = 8'($random(seed));
            wr(sar_adc_pkg::IDX_START, 4'h4);
            t0 = take;
            rd(sar_adc_pkg::IDX_START, 4'h4);
            // A second start mid-conversion must not restart it
            wr(sar_adc_pkg::IDX_START, 4'h4);
            `WAIT_FOR(o_irq === 1'b1)
            `CHK(cyc - t0, 9 * nstep + 2)
            `CHK(o_port_latch, 4'h0)
            rd(sar_adc_pkg::IDX_START, 4'h0);
            rd(sar_adc_pkg::IDX_RES_LO, ana[3:0]);
            rd(sar_adc_pkg::IDX_RES_HI, ana[7:4]);
            rd(sar_adc_pkg::IDX_IRQ_STAT, 4'h1);
            wr(sar_adc_pkg::IDX_IRQ_STAT, 4'h1);
            `CHK(o_irq, 1'b0)
        end
        wr(sar_adc_pkg::IDX_IRQ_MASK, 4'h0);
        ana = 8'($random(seed));
        wr(sar_adc_pkg::IDX_START, 4'h4);
        repeat (9 * NF + 4) @(posedge i_mclk);
        `CHK(o_irq, 1'b0)
        rd(sar_adc_pkg::IDX_IRQ_STAT, 4'h1);
        wr(sar_adc_pkg::IDX_IRQ_MASK, 4'h1);
        `CHK(o_irq, 1'b1)
        wr(sar_adc_pkg::IDX_IRQ_STAT, 4'h1);
        `CHK(o_irq, 1'b0)
        rd(sar_adc_pkg::IDX_RES_HI, ana[7:4]);
        i_arst_n <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        @(posedge i_mclk);
        `CHK(o_port_latch, 4'hF)
        rd(sar_adc_pkg::IDX_RES_LO, ana[3:0]);
        rd(sar_adc_pkg::IDX_RES_HI, ana[7:4]);
        give_verdict();
    end
endmodule : sar_adc_control_bench
